/* File: design/adcsq_defines.svh */
`ifndef ADCSQ_DEFINES_SVH
`define ADCSQ_DEFINES_SVH
// register word offsets (byte addresses)
`define ADCSQ_OFS_RES_LOW   8'h00
`define ADCSQ_OFS_RES_HIGH  8'h04
`define ADCSQ_OFS_CTRL0     8'h08
`define ADCSQ_OFS_CTRL1     8'h0C
`define ADCSQ_OFS_CTRL2     8'h10
`define ADCSQ_OFS_BANDGAP   8'h14
`define ADCSQ_OFS_IRQ_STAT  8'h18
`define ADCSQ_OFS_IRQ_MASK  8'h1C
// conv_control_0 fields
`define ADCSQ_C0_START      7
`define ADCSQ_C0_BUSY       6
`define ADCSQ_C0_EN         5
`define ADCSQ_C0_ALIGN      4
// reset values
`define ADCSQ_RST_CTRL0     8'h00
`define ADCSQ_RST_CTRL1     8'h00
`define ADCSQ_RST_CTRL2     8'h00
`define ADCSQ_RST_BANDGAP   8'h00
// write masks (unimplemented bits read zero)
`define ADCSQ_WMASK_CTRL0   8'hBF
`define ADCSQ_WMASK_CTRL1   8'hF7
`define ADCSQ_WMASK_CTRL2   8'h9F
`define ADCSQ_WMASK_BANDGAP 8'h01
// conversion length in converter clocks
`define ADCSQ_CONV_CLOCKS   5'd16
`define ADCSQ_NUM_CH        12
`endif

/* File: design/adcsq_pkg.sv */
`default_nettype none
package adcsq_pkg;
  typedef enum logic [1:0] {
    ADCSQ_IDLE = 2'b00,
    ADCSQ_CONV = 2'b01,
    ADCSQ_DONE = 2'b10
  } adcsq_state_e;
endpackage
`default_nettype wire

/* File: design/adcsq_top.sv */
// Functional notes
// - conversion starts only after start bit goes high then low again
// - busy flag rises at start, falls when the conversion completes or when enable is cleared mid-conversion
// - enable low powers converter off; result registers keep contents
// - align zero: high byte D11..D4, low byte upper nibble D3..D0
// - align one: high byte low nibble D11..D8, low byte D7..D0
// - unused result bit positions read as zero
// - each conversion yields a 12-bit value, external or internal source
// - channel codes 0..11 route external inputs 0..11 to converter
// - channel codes 12..15 connect no input
// - internal source selected disconnects external channel
// - converter-input pin loses digital function and pull-high
// - control register zero at reset; only busy flag read-only
// - source codes: external, supply, amp output scaled, or ground
// - clock field divides system clock by 1 to 128
`include "adcsq_defines.svh"
`default_nettype none
module adcsq_top (
  input  wire logic        sys_clk,
  input  wire logic        rst_b,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic [3:0]  wb_sel_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  output logic             wb_err_o,
  output logic             irq,
  input  wire logic [11:0] conv_sample,
  input  wire logic [11:0] pin_analog_sel,
  output logic             conv_power,
  output logic             conv_sample_clk,
  output logic [11:0]      ext_analog_inputs,
  output logic [2:0]       internal_sel,
  output logic [11:0]      pin_digital_off,
  output logic [11:0]      pin_pullup_off,
  output logic             gain_amp_enable,
  output logic             gain_amp_input_sel,
  output logic [1:0]       ref_voltage_sel,
  output logic [1:0]       gain_amp_gain_sel,
  output logic             bandgap_enable
);
  // ==========================================================
  // registers
  logic [7:0]  conv_control_0;
  logic [7:0]  conv_control_1;
  logic [7:0]  conv_control_2;
  logic [7:0]  bandgap_control;
  logic [11:0] result;
  logic        irq_stat;
  logic        irq_mask;
  logic        conv_busy_flag;
  adcsq_pkg::adcsq_state_e state;
  logic [6:0]  div_cnt;
  logic [4:0]  bit_cnt;
  logic        start_seen;
  logic        conv_done;

  logic        conv_enable;
  logic        result_align_sel;
  logic [3:0]  ext_channel_sel;
  logic [3:0]  input_source_sel;
  logic [2:0]  conv_clock_div_sel;
  assign conv_enable        = conv_control_0[`ADCSQ_C0_EN];
  assign result_align_sel   = conv_control_0[`ADCSQ_C0_ALIGN];
  assign ext_channel_sel    = conv_control_0[3:0];
  assign input_source_sel   = conv_control_1[7:4];
  assign conv_clock_div_sel = conv_control_1[2:0];

  // ==========================================================
  // bus slave
  logic req;
  logic wr;
  logic mapped;
  assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
  assign wr  = req & wb_we_i & wb_sel_i[0] & mapped;
  always_comb begin
    case (wb_adr_i)
      `ADCSQ_OFS_RES_LOW, `ADCSQ_OFS_RES_HIGH, `ADCSQ_OFS_CTRL0,
      `ADCSQ_OFS_CTRL1, `ADCSQ_OFS_CTRL2, `ADCSQ_OFS_BANDGAP,
      `ADCSQ_OFS_IRQ_STAT, `ADCSQ_OFS_IRQ_MASK: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      wb_ack_o <= 1'b0;
      wb_err_o <= 1'b0;
    end else begin
      wb_ack_o <= req & mapped;
      wb_err_o <= req & ~mapped;
    end
  end

  logic [7:0] rd_byte;
  always_comb begin
    rd_byte = 8'h00;
    case (wb_adr_i)
      `ADCSQ_OFS_RES_LOW:  rd_byte = result_align_sel ? result[7:0]
                                                      : {result[3:0], 4'h0};
      `ADCSQ_OFS_RES_HIGH: rd_byte = result_align_sel ? {4'h0, result[11:8]}
                                                      : result[11:4];
      `ADCSQ_OFS_CTRL0:    rd_byte = {conv_control_0[7], conv_busy_flag,
                                      conv_control_0[5:0]};
      `ADCSQ_OFS_CTRL1:    rd_byte = conv_control_1;
      `ADCSQ_OFS_CTRL2:    rd_byte = conv_control_2;
      `ADCSQ_OFS_BANDGAP:  rd_byte = bandgap_control;
      `ADCSQ_OFS_IRQ_STAT: rd_byte = {7'h00, irq_stat};
      `ADCSQ_OFS_IRQ_MASK: rd_byte = {7'h00, irq_mask};
      default:             rd_byte = 8'h00;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (req) begin
      wb_dat_o <= {24'h00_0000, rd_byte};
    end
  end

  // ==========================================================
  // control registers
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      conv_control_0  <= `ADCSQ_RST_CTRL0;
      conv_control_1  <= `ADCSQ_RST_CTRL1;
      conv_control_2  <= `ADCSQ_RST_CTRL2;
      bandgap_control <= `ADCSQ_RST_BANDGAP;
      irq_mask        <= 1'b0;
    end else if (wr) begin
      case (wb_adr_i)
        `ADCSQ_OFS_CTRL0:    conv_control_0 <= wb_dat_i[7:0] & `ADCSQ_WMASK_CTRL0;
        `ADCSQ_OFS_CTRL1:    conv_control_1 <= wb_dat_i[7:0] & `ADCSQ_WMASK_CTRL1;
        `ADCSQ_OFS_CTRL2:    conv_control_2 <= wb_dat_i[7:0] & `ADCSQ_WMASK_CTRL2;
        `ADCSQ_OFS_BANDGAP:  bandgap_control <= wb_dat_i[7:0] & `ADCSQ_WMASK_BANDGAP;
        `ADCSQ_OFS_IRQ_MASK: irq_mask <= wb_dat_i[0];
        default: ;
      endcase
    end
  end

  // ==========================================================
  // start detection
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      start_seen <= 1'b0;
    end else begin
      start_seen <= conv_control_0[`ADCSQ_C0_START];
    end
  end
  logic start_pulse;
  assign start_pulse = start_seen & ~conv_control_0[`ADCSQ_C0_START];

  // ==========================================================
  // conversion clock divider
  logic [6:0] div_limit;
  logic       conv_tick;
  assign div_limit = 7'((8'h01 << conv_clock_div_sel) - 8'h01);
  assign conv_tick = (div_cnt == div_limit);
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      div_cnt <= 7'h00;
    end else if (state != adcsq_pkg::ADCSQ_CONV || conv_tick) begin
      div_cnt <= 7'h00;
    end else begin
      div_cnt <= div_cnt + 7'h01;
    end
  end
  assign conv_sample_clk = (state == adcsq_pkg::ADCSQ_CONV) & conv_tick;

  // ==========================================================
  // sequencer
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      state          <= adcsq_pkg::ADCSQ_IDLE;
      bit_cnt        <= 5'd0;
      conv_busy_flag <= 1'b0;
      result         <= 12'h000;
    end else begin
      case (state)
        adcsq_pkg::ADCSQ_IDLE: begin
          if (start_pulse && conv_enable) begin
            state          <= adcsq_pkg::ADCSQ_CONV;
            bit_cnt        <= 5'd0;
            conv_busy_flag <= 1'b1;
          end
        end
        adcsq_pkg::ADCSQ_CONV: begin
          if (!conv_enable) begin
            state          <= adcsq_pkg::ADCSQ_IDLE;
            conv_busy_flag <= 1'b0;
          end else if (conv_tick) begin
            if (bit_cnt == `ADCSQ_CONV_CLOCKS - 5'd1) begin
              result <= conv_sample;
              state  <= adcsq_pkg::ADCSQ_DONE;
            end else begin
              bit_cnt <= bit_cnt + 5'd1;
            end
          end
        end
        adcsq_pkg::ADCSQ_DONE: begin
          conv_busy_flag <= 1'b0;
          state          <= adcsq_pkg::ADCSQ_IDLE;
        end
        default: state <= adcsq_pkg::ADCSQ_IDLE;
      endcase
    end
  end
  assign conv_done = (state == adcsq_pkg::ADCSQ_DONE);

  // ==========================================================
  // interrupt
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_stat <= 1'b0;
    end else if (conv_done) begin
      irq_stat <= 1'b1;
    end else if (wr && wb_adr_i == `ADCSQ_OFS_IRQ_STAT && wb_dat_i[0]) begin
      irq_stat <= 1'b0;
    end
  end
  assign irq = irq_stat & irq_mask;

  // ==========================================================
  // analog routing
  logic src_external;
  always_comb begin
    case (input_source_sel)
      4'h0, 4'h4, 4'hC, 4'hD, 4'hE, 4'hF: src_external = 1'b1;
      default:                           src_external = 1'b0;
    endcase
  end
  always_comb begin
    case (input_source_sel)
      4'h1, 4'h2, 4'h3: internal_sel = {1'b0, input_source_sel[1:0]};
      4'h5, 4'h6, 4'h7: internal_sel = {1'b1, input_source_sel[1:0]};
      default:          internal_sel = 3'h0;
    endcase
  end

  genvar gi;
  generate
    for (gi = 0; gi < `ADCSQ_NUM_CH; gi++) begin : g_ch
      assign ext_analog_inputs[gi] = conv_enable & src_external &
                                     (ext_channel_sel == 4'(gi));
      assign pin_digital_off[gi] = pin_analog_sel[gi];
      assign pin_pullup_off[gi]  = pin_analog_sel[gi];
    end
  endgenerate

  assign conv_power         = conv_enable;
  assign gain_amp_enable    = conv_control_2[7];
  assign gain_amp_input_sel = conv_control_2[4];
  assign ref_voltage_sel    = conv_control_2[3:2];
  assign gain_amp_gain_sel  = conv_control_2[1:0];
  assign bandgap_enable     = bandgap_control[0];
endmodule
`default_nettype wire

/* File: sim/adcsq_top_properties.sv */
`default_nettype none
module adcsq_top_chk (
  input wire logic        sys_clk,
  input wire logic        rst_b,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        wb_err_o,
  input wire logic        irq,
  input wire logic [11:0] pin_analog_sel,
  input wire logic        conv_power,
  input wire logic [11:0] ext_analog_inputs,
  input wire logic [2:0]  internal_sel,
  input wire logic [11:0] pin_digital_off,
  input wire logic [11:0] pin_pullup_off
);
  // ==========================================
  // alignment tracking
  logic align_q;
  logic wr_c0;
  assign wr_c0 = wb_ack_o && wb_we_i && wb_adr_i == 8'h08 && wb_sel_i[0];
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) align_q <= 1'b0;
    else if (wr_c0) align_q <= wb_dat_i[4];
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  // ==========================================
  // properties
  AST_PIN_DIG: assert property (pin_digital_off == pin_analog_sel)
    else $error("digital off mismatch");
  AST_PIN_PU: assert property (pin_pullup_off == pin_analog_sel)
    else $error("pull-up off mismatch");
  AST_ONEHOT: assert property ($onehot0(ext_analog_inputs))
    else $error("several channels closed");
  AST_INT_OFF: assert property (internal_sel != 3'h0 |-> ext_analog_inputs == 12'h000)
    else $error("external switch closed with internal source");
  AST_PWR_OFF: assert property (!conv_power |-> ext_analog_inputs == 12'h000)
    else $error("switch closed while off");
  AST_EN_WR: assert property (wr_c0 |=> conv_power == $past(wb_dat_i[5]))
    else $error("power not following enable write");
  AST_HI_ZERO: assert property (wb_ack_o && !wb_we_i && wb_adr_i == 8'h04 && align_q
    |-> wb_dat_o[7:4] == 4'h0) else $error("high byte unused bits set");
  AST_LO_ZERO: assert property (wb_ack_o && !wb_we_i && wb_adr_i == 8'h00 && !align_q
    |-> wb_dat_o[3:0] == 4'h0) else $error("low byte unused bits set");
  AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  AST_ERR_ONLY: assert property (wb_err_o |-> !wb_ack_o)
    else $error("err with ack");
  AST_RST: assert property ($rose(rst_b) |-> !conv_power && !irq)
    else $error("not idle after reset");
endmodule
bind adcsq_top adcsq_top_chk u_adcsq_top_chk (.*);
`default_nettype wire

/* File: sim/adcsq_top_tb.sv */
`default_nettype none
module adcsq_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk = 1'b0, rst_b = 1'b0, req = 1'b0, we = 1'b0, gerr, ack, err, irq;
  logic [7:0]  adr = 8'h00, rd;
  logic [31:0] wdat = 32'h0000_0000, dat_o;
  logic [11:0] samp = 12'h000, pin_sel = 12'h0F0, ext_in;
  logic [2:0]  int_sel;
  int n_fail = 0, compares = 0;
  always #25 sys_clk = ~sys_clk;
  adcsq_top u_adcsq_top (.sys_clk(sys_clk), .rst_b(rst_b), .wb_cyc_i(req), .wb_stb_i(req),
    .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(4'h1), .wb_dat_o(dat_o),
    .wb_ack_o(ack), .wb_err_o(err), .irq(irq), .conv_sample(samp),
    .pin_analog_sel(pin_sel), .conv_power(), .conv_sample_clk(), .ext_analog_inputs(ext_in),
    .internal_sel(int_sel), .pin_digital_off(), .pin_pullup_off(), .gain_amp_enable(),
    .gain_amp_input_sel(), .ref_voltage_sel(), .gain_amp_gain_sel(), .bandgap_enable());
  // ==========================================
  // shared tasks
  task automatic close_out();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [11:0] s, input logic [11:0] e);
    compares++;
    if (s !== e) begin
      n_fail++;
      $display("unexpected %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int i;
    req <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {24'h00_0000, d};
    i = 0;
    do begin
      @(negedge sys_clk);
      i++;
    end while (ack !== 1'b1 && err !== 1'b1 && i < 20);
    rd = dat_o[7:0];
    gerr = err;
    if (i >= 20) begin
      n_fail++;
      close_out();
    end
    @(posedge sys_clk);
    req <= 1'b0;
    @(posedge sys_clk);
  endtask
  // ==========================================
  // scenarios
  task automatic t_reset();
    for (int k = 0; k < 4; k++) begin
      wb(1'b0, 8'h08 + 8'(4 * k), 8'h00);
      chk("ctrl reset", rd, 12'h000);
    end
    wb(1'b0, 8'h40, 8'h00);
    chk("unmapped err", gerr, 12'h001);
  endtask
  task automatic t_conv();
    int k;
    samp <= 12'hABC;
    wb(1'b1, 8'h0C, 8'h00);
    wb(1'b1, 8'h08, 8'hA3);
    wb(1'b1, 8'h08, 8'h23);
    chk("channel", ext_in, 12'h008);
    wb(1'b0, 8'h08, 8'h00);
    chk("busy set", rd[6], 12'h001);
    for (k = 0; k < 40 && rd[6]; k++) wb(1'b0, 8'h08, 8'h00);
    chk("busy clear", rd[6], 12'h000);
    wb(1'b0, 8'h04, 8'h00);
    chk("high left", rd, 12'h0AB);
    wb(1'b0, 8'h00, 8'h00);
    chk("low left", rd, 12'h0C0);
    wb(1'b1, 8'h08, 8'h33);
    wb(1'b0, 8'h04, 8'h00);
    chk("high right", rd, 12'h00A);
    wb(1'b0, 8'h00, 8'h00);
    chk("low right", rd, 12'h0BC);
    wb(1'b0, 8'h18, 8'h00);
    chk("done flag", rd[0], 12'h001);
    chk("irq masked", irq, 12'h000);
    wb(1'b1, 8'h1C, 8'h01);
    chk("irq on", irq, 12'h001);
    wb(1'b1, 8'h18, 8'h01);
    chk("irq cleared", irq, 12'h000);
  endtask
  task automatic t_off();
    wb(1'b1, 8'h08, 8'h00);
    samp <= 12'h123;
    wb(1'b1, 8'h08, 8'h80);
    wb(1'b1, 8'h08, 8'h00);
    wb(1'b0, 8'h08, 8'h00);
    chk("busy while off", rd[6], 12'h000);
    wb(1'b0, 8'h04, 8'h00);
    chk("result kept", rd, 12'h0AB);
  endtask
  task automatic t_source();
    wb(1'b1, 8'h08, 8'h2C);
    chk("no channel", ext_in, 12'h000);
    wb(1'b1, 8'h08, 8'h23);
    for (int k = 0; k < 16; k++) begin
      wb(1'b1, 8'h0C, {4'(k), 4'h0});
      chk("source", int_sel, (k[3] || k[1:0] == 0) ? 12'h000 : {k[2], k[1:0]});
      if (k[3:2] != 2'b10) chk("ext off", ext_in, (k[3] || k[1:0] == 0) ? 12'h008 : 12'h000);
    end
  endtask
  initial begin
    repeat (8) @(posedge sys_clk);
    rst_b <= 1'b1;
    @(posedge sys_clk);
    t_reset();
    t_conv();
    t_off();
    t_source();
    close_out();
  end
endmodule
`default_nettype wire
